// File: logic/pef_pkg.sv
/*
 * Constants for the peripheral event flag block: register offsets, bit
 * positions, implemented-bit mask and reset values.
 * Assumes an 8-bit data path and a byte-wide register address.
 */
package pef_pkg;

    localparam int PEF_DATA_W = 8;
    localparam int PEF_ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] PEF_OFS_FLAGS = 8'h0c;
    localparam logic [7:0] PEF_OFS_IRQ_STATUS = 8'h0d;
    localparam logic [7:0] PEF_OFS_IRQ_MASK = 8'h0e;

    ////////////////////////////////////////////////////////////////////////////////
    // bit positions, shared by flags, status and mask
    localparam int PEF_BIT_EE_DONE = 7;
    localparam int PEF_BIT_ADC_DONE = 6;
    localparam int PEF_BIT_CAP_CMP = 5;
    localparam int PEF_BIT_UNUSED = 4;
    localparam int PEF_BIT_CMP_CHANGE = 3;
    localparam int PEF_BIT_OSC_FAIL = 2;
    localparam int PEF_BIT_TB_MATCH = 1;
    localparam int PEF_BIT_TA_OVF = 0;

    // bit 4 is not implemented and reads zero
    localparam logic [7:0] PEF_IMPL_MASK = 8'hef;

    ////////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] PEF_RST_FLAGS = 8'h00;
    localparam logic [7:0] PEF_RST_IRQ_STATUS = 8'h00;
    localparam logic [7:0] PEF_RST_IRQ_MASK = 8'h00;
    localparam logic [7:0] PEF_RST_RDATA = 8'h00;
    localparam logic PEF_RST_BIT = 1'b0;

endpackage

// File: logic/pef_sticky_bit.sv
/*
 * One sticky flag bit: set by a hardware event, loaded or cleared by
 * software. Assumes all controls are synchronous to the clock.
 */
module pef_sticky_bit
    import pef_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_set,
    input wire logic i_load,
    input wire logic i_load_value,
    input wire logic i_clear,
    output logic o_bit
);

    logic bit_reg;
    logic bit_next;

    // set wins over a load or clear in the same cycle, so no event is lost
    assign bit_next = i_set ? 1'b1 :
                      i_load ? i_load_value :
                      i_clear ? 1'b0 : bit_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_reg <= PEF_RST_BIT;
        end else begin
            bit_reg <= bit_next;
        end
    end

    assign o_bit = bit_reg;

endmodule

// File: logic/pef_top.sv
/*
 * Peripheral event flag register with a read-clear interrupt status
 * register, an interrupt mask and one level interrupt output.
 * Bit 4 has no storage and reads zero in every word.
 * An event beats a software clear that lands in the same cycle.
 * Assumes a single clock, synchronous event inputs and a register master
 * that issues one-cycle strobes and never waits.
 */
// Our own choice: the address-and-strobe port.
//
// How it works
// RULE1: each event sets its flag whatever its per-source enable says.
// RULE2: flags set regardless of the global interrupt enable; that only gates taking.
// RULE3: software should clear a pending flag before enabling its source.
// RULE4: eeprom write completion sets bit 7; held until software writes zero.
// RULE5: bit 7 reads zero while an eeprom write is still running.
// RULE6: flag register at offset 0x0c, implemented bits read/write, zero at reset.
// RULE7: bits 6..0 from adc, capture/compare, comparator, oscillator, timers; bit 4 zero.
module pef_top
    import pef_pkg::*;
#(
    parameter int DATA_W = PEF_DATA_W,
    parameter int ADDR_W = PEF_ADDR_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_ee_write_busy,
    input wire logic i_adc_done,
    input wire logic i_capture_compare_event,
    input wire logic i_comparator_out,
    input wire logic i_oscillator_fail,
    input wire logic i_timer_b_period_match,
    input wire logic i_timer_a_overflow,
    input wire logic i_global_irq_enable,
    output logic [DATA_W-1:0] o_flags,
    output logic o_irq,
    output logic o_irq_taken
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic ee_busy_prev_reg;
    logic cmp_prev_reg;
    logic cmp_primed_reg;
    logic [DATA_W-1:0] irq_mask_reg;
    logic [DATA_W-1:0] irq_mask_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    logic [DATA_W-1:0] event_vec;
    logic [DATA_W-1:0] flags_q;
    logic [DATA_W-1:0] status_q;
    logic [DATA_W-1:0] flags_visible;
    logic [DATA_W-1:0] ee_busy_hide;
    logic [DATA_W-1:0] impl_mask;
    logic [DATA_W-1:0] rd_word_flags;
    logic [DATA_W-1:0] rd_word_status;
    logic [DATA_W-1:0] rd_word_mask;
    logic [DATA_W-1:0] rd_word_sel;
    logic [DATA_W-1:0] irq_pending;

    logic ee_write_done;
    logic cmp_changed;
    logic sel_flags;
    logic sel_status;
    logic sel_mask;
    logic wr_flags;
    logic wr_mask;
    logic rd_status;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    assign sel_flags = (i_addr == ADDR_W'(PEF_OFS_FLAGS));
    assign sel_status = (i_addr == ADDR_W'(PEF_OFS_IRQ_STATUS));
    assign sel_mask = (i_addr == ADDR_W'(PEF_OFS_IRQ_MASK));

    // RULE6: flag register decode
    assign wr_flags = i_wr & sel_flags;
    assign wr_mask = i_wr & sel_mask;
    assign rd_status = i_rd & sel_status;

    // keeps bit 4 out of the mask word too
    assign impl_mask = DATA_W'(PEF_IMPL_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // event detection

    // a write that ends inside reset is lost: no busy high seen yet
    // RULE4: write done on busy fall
    assign ee_write_done = ee_busy_prev_reg & ~i_ee_write_busy;

    // first sample after reset only primes, so a high level is no change
    assign cmp_changed = cmp_primed_reg & (cmp_prev_reg ^ i_comparator_out);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ee_busy_prev_reg <= PEF_RST_BIT;
        end else begin
            ee_busy_prev_reg <= i_ee_write_busy;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cmp_prev_reg <= PEF_RST_BIT;
            cmp_primed_reg <= PEF_RST_BIT;
        end else begin
            cmp_prev_reg <= i_comparator_out;
            cmp_primed_reg <= 1'b1;
        end
    end

    // RULE7: event to bit mapping
    always_comb begin
        event_vec = '0;
        event_vec[PEF_BIT_EE_DONE] = ee_write_done;
        event_vec[PEF_BIT_ADC_DONE] = i_adc_done;
        event_vec[PEF_BIT_CAP_CMP] = i_capture_compare_event;
        event_vec[PEF_BIT_CMP_CHANGE] = cmp_changed;
        event_vec[PEF_BIT_OSC_FAIL] = i_oscillator_fail;
        event_vec[PEF_BIT_TB_MATCH] = i_timer_b_period_match;
        event_vec[PEF_BIT_TA_OVF] = i_timer_a_overflow;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // flag and status bits

    genvar k;
    generate
        for (k = 0; k < DATA_W; k++) begin : g_bit
            if (PEF_IMPL_MASK[k]) begin : g_impl
                // a software write of one sets the flag as well
                // RULE1: set with no enable term
                // RULE2: global enable not consulted
                pef_sticky_bit u_flag (
                    .i_ref_clk(i_ref_clk),
                    .i_rst(i_rst),
                    .i_set(event_vec[k]),
                    .i_load(wr_flags),
                    .i_load_value(i_wdata[k]),
                    .i_clear(1'b0),
                    .o_bit(flags_q[k])
                );

                // status copy, cleared by reading it
                pef_sticky_bit u_status (
                    .i_ref_clk(i_ref_clk),
                    .i_rst(i_rst),
                    .i_set(event_vec[k]),
                    .i_load(1'b0),
                    .i_load_value(1'b0),
                    .i_clear(rd_status),
                    .o_bit(status_q[k])
                );
            end else begin : g_none
                // RULE7: bit 4 reads zero
                assign flags_q[k] = 1'b0;
                assign status_q[k] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // read view of the flags

    // RULE5: hide done while busy
    always_comb begin
        ee_busy_hide = '0;
        ee_busy_hide[PEF_BIT_EE_DONE] = i_ee_write_busy;
    end

    assign flags_visible = flags_q & ~ee_busy_hide;

    ////////////////////////////////////////////////////////////////////////////////
    // mask register and read data

    assign irq_mask_next = wr_mask ? (i_wdata & impl_mask) : irq_mask_reg;

    // one word per register; selects are exclusive, unmapped reads answer zero
    assign rd_word_flags = sel_flags ? flags_visible : '0;
    assign rd_word_status = sel_status ? status_q : '0;
    assign rd_word_mask = sel_mask ? irq_mask_reg : '0;
    assign rd_word_sel = rd_word_flags | rd_word_status | rd_word_mask;

    // data hold between reads
    assign rdata_next = i_rd ? rd_word_sel : rdata_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_mask_reg <= DATA_W'(PEF_RST_IRQ_MASK);
        end else begin
            irq_mask_reg <= irq_mask_next;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= DATA_W'(PEF_RST_RDATA);
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // read data appears in the cycle after the strobe and holds until the next read
    assign o_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // raw flag state; the busy masking applies to register reads only
    assign o_flags = flags_q;

    // level output: drops only when the status word is read or the mask clears
    assign irq_pending = status_q & irq_mask_reg;
    assign o_irq = |irq_pending;

    // RULE2: enable only gates taking
    assign o_irq_taken = o_irq & i_global_irq_enable;

endmodule

// File: bench/pef_top_properties.sv
/* concurrent checks on the pef_top ports, bound into every pef_top.
   assumes one clock and an active-high asynchronous reset. */
module pef_top_checker
    import pef_pkg::*;
#(
    parameter int DATA_W = PEF_DATA_W,
    parameter int ADDR_W = PEF_ADDR_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic i_ee_write_busy,
    input wire logic i_comparator_out,
    input wire logic i_timer_b_period_match,
    input wire logic i_timer_a_overflow,
    input wire logic [DATA_W-1:0] o_flags
);
default clocking cb @(posedge i_ref_clk); endclocking
default disable iff (i_rst);
wire logic flag_wr = i_wr && i_addr == PEF_OFS_FLAGS;
wire logic flag_rd = i_rd && i_addr == PEF_OFS_FLAGS;
wire logic [7:0] wmask = i_wdata & PEF_IMPL_MASK;
////////////////////////////////////////////////////////////////////////////////
property p_ta_set; i_timer_a_overflow |=> o_flags[PEF_BIT_TA_OVF]; endproperty
a_ta_set: assert property (p_ta_set) else $error("timer a flag missed");
property p_tb_set; i_timer_b_period_match |=> o_flags[PEF_BIT_TB_MATCH]; endproperty
a_tb_set: assert property (p_tb_set) else $error("timer b flag missed");
property p_ee_set; $fell(i_ee_write_busy) && !$past(i_rst) |=> o_flags[7]; endproperty
a_ee_set: assert property (p_ee_set) else $error("write done flag missed");
property p_ee_hold; o_flags[7] && !flag_wr |=> o_flags[7]; endproperty
a_ee_hold: assert property (p_ee_hold) else $error("write done flag lost");
property p_ee_gate; flag_rd && i_ee_write_busy |=> !o_rdata[7]; endproperty
a_ee_gate: assert property (p_ee_gate) else $error("bit 7 read while busy");
property p_rd_flags; flag_rd && !i_ee_write_busy |=> o_rdata == $past(o_flags); endproperty
a_rd_flags: assert property (p_rd_flags) else $error("flag read wrong");
property p_wr_flags;
    flag_wr |=> (o_flags & $past(wmask)) == $past(wmask) && !o_flags[PEF_BIT_UNUSED];
endproperty
a_wr_flags: assert property (p_wr_flags) else $error("flag write wrong");
property p_wr_clear;
    flag_wr && !i_wdata[PEF_BIT_TA_OVF] && !i_timer_a_overflow |=> !o_flags[PEF_BIT_TA_OVF];
endproperty
a_wr_clear: assert property (p_wr_clear) else $error("flag clear lost");
property p_cmp_set; $changed(i_comparator_out) && !$past(i_rst) |=> o_flags[3]; endproperty
a_cmp_set: assert property (p_cmp_set) else $error("comparator flag missed");
endmodule

bind pef_top pef_top_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_pef_top_checker (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_ee_write_busy(i_ee_write_busy),
    .i_comparator_out(i_comparator_out), .i_timer_b_period_match(i_timer_b_period_match),
    .i_timer_a_overflow(i_timer_a_overflow), .o_flags(o_flags));

// File: bench/pef_top_test.sv
/* self-checking bench for pef_top: register tasks plus event pulses.
   assumes the bench drives every port itself, no partner model. */
module pef_top_test;
timeunit 1ns;
timeprecision 1ps;
import pef_pkg::*;
logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, busy = 0, global_irq_enable = 0;
logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, o_flags;
logic [6:0] ev = 0;
logic o_irq, o_irq_taken;
int num_errors = 0, checks_done = 0, cyc = 0;
pef_top u_pef_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ee_write_busy(busy), .i_adc_done(ev[6]),
    .i_capture_compare_event(ev[5]), .i_comparator_out(ev[3]), .i_oscillator_fail(ev[2]),
    .i_timer_b_period_match(ev[1]), .i_timer_a_overflow(ev[0]), .i_global_irq_enable(global_irq_enable),
    .o_flags(o_flags), .o_irq(o_irq), .o_irq_taken(o_irq_taken));
initial forever #4 i_ref_clk = ~i_ref_clk;
always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
        num_errors++;
        results();
    end
end
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
        num_errors++;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_ref_clk) i_wr <= 0;
endtask
task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_ref_clk) i_rd <= 0;
    #1 chk(o_rdata, exp);
endtask
task automatic pulse(input int b);
    @(posedge i_ref_clk) ev[b] <= 1;
    @(posedge i_ref_clk) ev[b] <= 0;
    #1;
endtask
task automatic set_busy(input logic v);
    @(posedge i_ref_clk) busy <= v;
endtask
// flag write of zero and an event in the same cycle
task automatic wr_clash(input int b);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= PEF_OFS_FLAGS;
    i_wdata <= 8'h00;
    ev[b] <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    ev[b] <= 1'b0;
endtask
task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 0;
    rd(PEF_OFS_FLAGS, 8'h00);
    rd(PEF_OFS_IRQ_MASK, 8'h00);
    wr(PEF_OFS_FLAGS, 8'hff);
    rd(PEF_OFS_FLAGS, 8'hef);
    wr(PEF_OFS_FLAGS, 8'h00);
    rd(PEF_OFS_IRQ_STATUS, 8'h00);
    rd(8'h55, 8'h00);
    wr(PEF_OFS_IRQ_MASK, 8'hff);
    rd(PEF_OFS_IRQ_MASK, 8'hef);
    chk({7'h00, o_irq}, 8'h00);
    for (int b = 0; b < 7; b++) if (b != 4) begin
        @(posedge i_ref_clk) global_irq_enable <= b[0];
        pulse(b);
        chk({6'h00, o_irq_taken, o_irq}, {6'h00, b[0], 1'b1});
        chk(o_flags, 8'h01 << b);
        rd(PEF_OFS_FLAGS, 8'h01 << b);
        rd(PEF_OFS_FLAGS, 8'h01 << b);
        wr(PEF_OFS_FLAGS, 8'h00);
        rd(PEF_OFS_IRQ_STATUS, 8'h01 << b);
        chk({7'h00, o_irq}, 8'h00);
    end
    // write completion only once busy drops
    set_busy(1'b1);
    rd(PEF_OFS_FLAGS, 8'h00);
    set_busy(1'b0);
    rd(PEF_OFS_FLAGS, 8'h80);
    rd(PEF_OFS_FLAGS, 8'h80);
    set_busy(1'b1);
    rd(PEF_OFS_FLAGS, 8'h00);
    chk(o_flags, 8'h80);
    set_busy(1'b0);
    wr(PEF_OFS_FLAGS, 8'h00);
    rd(PEF_OFS_FLAGS, 8'h00);
    rd(PEF_OFS_IRQ_STATUS, 8'h80);
    // masked source still flags, no irq
    wr(PEF_OFS_IRQ_MASK, 8'h00);
    pulse(0);
    chk({7'h00, o_irq}, 8'h00);
    rd(PEF_OFS_IRQ_STATUS, 8'h01);
    rd(PEF_OFS_FLAGS, 8'h01);
    // event beats a clear in the same cycle
    wr_clash(1);
    rd(PEF_OFS_FLAGS, 8'h02);
    rd(PEF_OFS_IRQ_STATUS, 8'h02);
    results();
end
endmodule
